// *** rtl/adc_conversion_sequencer.sv ***
module adc_conversion_sequencer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hardware_trigger_input,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic alternate_clock,
   input wire logic async_conversion_clock,
   input wire logic [9:0] core_result,
   output logic conversion_irq,
   output logic async_clock_enable,
   output logic core_sample,
   output logic core_convert,
   output logic [4:0] core_channel,
   output logic core_low_power,
   output logic core_ten_bit
);
   // ==========================================================
   // state
   typedef struct packed {
      logic awready;
      logic wready;
      logic have_aw;
      logic have_w;
      logic [4:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] sc1;
      logic [7:0] sc2;
      logic [7:0] cfg;
      logic [9:0] compare;
      logic [9:0] result;
      logic read_half;
      logic [2:0] trig_sync;
      logic [1:0] wait_sync;
      logic [1:0] stop_sync;
      adc_seq_pkg::seq_state_t state;
      logic first;
      logic [5:0] count;
      logic [2:0] bus_count;
      logic irq;
   } core_state_t;

   core_state_t r;
   core_state_t next_r;
   logic tick;
   logic conv_run;

   // ==========================================================
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic mapped(input logic [4:0] a);
      return a[1:0] == 2'h0 && a <= adc_seq_pkg::mode_control_addr;
   endfunction : mapped

   conv_clock_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(conv_run),
      .source_select(r.cfg[1:0]),
      .divide_select(r.cfg[6:5]),
      .alternate_clock(alternate_clock),
      .async_conversion_clock(async_conversion_clock),
      .tick(tick)
   );

   assign conv_run = r.state != adc_seq_pkg::st_idle;

   // ==========================================================
   // next state
   always_comb begin
      logic wr_go;
      logic [31:0] wv;
      logic [7:0] wb;
      logic start;
      logic abort;
      logic restart;
      logic trig_rise;
      logic async_sel;
      logic ten;
      logic [10:0] diff;
      logic [9:0] cmp;
      logic [9:0] res;
      logic hit;
      logic do_store;
      wr_go = 1'b0;
      wv = 32'h0;
      wb = 8'h0;
      start = 1'b0;
      abort = 1'b0;
      restart = 1'b0;
      diff = 11'h0;
      hit = 1'b0;
      do_store = 1'b0;
      res = 10'h0;
      cmp = 10'h0;
      next_r = r;
      next_r.trig_sync = {r.trig_sync[1:0], hardware_trigger_input};
      next_r.wait_sync = {r.wait_sync[0], wait_mode};
      next_r.stop_sync = {r.stop_sync[0], stop_mode};
      trig_rise = r.trig_sync[1] & ~r.trig_sync[2];
      async_sel = r.cfg[1:0] == adc_seq_pkg::clock_async;
      ten = r.cfg[3:2] == adc_seq_pkg::mode_ten_bit;
      // bus write channels
      if (s_axi_awvalid && r.awready) begin
         next_r.have_aw = 1'b1;
         next_r.waddr = s_axi_awaddr;
         next_r.awready = 1'b0;
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.have_w = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
         next_r.wready = 1'b0;
      end
      if (r.have_aw && r.have_w && !r.bvalid) begin
         wr_go = mapped(r.waddr);
         wv = merge(32'h0, r.wdata, r.wstrb);
         wb = wv[7:0];
         next_r.have_aw = 1'b0;
         next_r.have_w = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = wr_go ? adc_seq_pkg::resp_okay
                              : adc_seq_pkg::resp_slverr;
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready = 1'b1;
      end
      if (wr_go && r.wstrb[0]) begin
         case (r.waddr)
            adc_seq_pkg::status_control_first_addr: begin
               next_r.sc1[6:0] = wb[6:0];
               abort = 1'b1;
               start = wb[4:0] != adc_seq_pkg::channel_disabled;
            end
            adc_seq_pkg::status_control_second_addr: begin
               next_r.sc2[6:4] = wb[6:4];
               abort = 1'b1;
            end
            adc_seq_pkg::compare_value_high_addr: begin
               next_r.compare[9:8] = wb[1:0];
               abort = 1'b1;
            end
            adc_seq_pkg::compare_value_low_addr: begin
               next_r.compare[7:0] = wb;
               abort = 1'b1;
            end
            adc_seq_pkg::converter_configuration_addr: begin
               next_r.cfg = wb;
               abort = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // bus read channel
      if (s_axi_arvalid && r.arready) begin
         next_r.arready = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rresp = mapped(s_axi_araddr) ? adc_seq_pkg::resp_okay
                                             : adc_seq_pkg::resp_slverr;
         case (s_axi_araddr)
            adc_seq_pkg::status_control_first_addr:
               next_r.rdata = {24'h0, r.sc1};
            adc_seq_pkg::status_control_second_addr:
               next_r.rdata = {24'h0, conv_run, r.sc2[6:4], 4'h0};
            adc_seq_pkg::result_high_addr: begin
               next_r.rdata = {30'h0, r.result[9:8]};
               next_r.read_half = ten;
            end
            adc_seq_pkg::result_low_addr: begin
               next_r.rdata = {24'h0, r.result[7:0]};
               next_r.read_half = 1'b0;
               next_r.sc1[adc_seq_pkg::sc1_complete_bit] = 1'b0;
            end
            adc_seq_pkg::compare_value_high_addr:
               next_r.rdata = {30'h0, r.compare[9:8]};
            adc_seq_pkg::compare_value_low_addr:
               next_r.rdata = {24'h0, r.compare[7:0]};
            adc_seq_pkg::converter_configuration_addr:
               next_r.rdata = {24'h0, r.cfg};
            adc_seq_pkg::mode_control_addr:
               next_r.rdata = {30'h0, r.stop_sync[1], r.wait_sync[1]};
            default:
               next_r.rdata = 32'h0;
         endcase
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
         next_r.arready = 1'b1;
      end
      // hardware trigger honoured only while idle, also in wait, in stop only with the async clock
      if (r.sc2[adc_seq_pkg::sc2_hw_trigger_bit] && trig_rise
          && r.state == adc_seq_pkg::st_idle) begin
         start = 1'b1;
      end
      if (r.sc2[adc_seq_pkg::sc2_hw_trigger_bit]) begin
         start = start & trig_rise;
      end
      // software start is a bus write, impossible while the cpu sleeps
      // conversion sequencer
      case (r.state)
         adc_seq_pkg::st_idle: begin
         end
         adc_seq_pkg::st_startup: begin
            if (r.count == 6'h0) begin
               next_r.state = adc_seq_pkg::st_sample;
               next_r.count = r.cfg[adc_seq_pkg::cfg_long_sample_bit]
                  ? adc_seq_pkg::sample_long_cycles
                  : adc_seq_pkg::sample_short_cycles;
            end else begin
               next_r.count = r.count - 6'h1;
            end
         end
         adc_seq_pkg::st_sample: begin
            if (tick) begin
               if (r.count == 6'h0) begin
                  next_r.state = adc_seq_pkg::st_approx;
                  next_r.count = (ten ? adc_seq_pkg::approx_10bit_cycles
                                      : adc_seq_pkg::approx_8bit_cycles)
                     + (r.first ? adc_seq_pkg::first_extra_cycles
                                : 6'h0);
               end else begin
                  next_r.count = r.count - 6'h1;
               end
            end
         end
         adc_seq_pkg::st_approx: begin
            if (tick) begin
               if (r.count == 6'h0) begin
                  next_r.state = adc_seq_pkg::st_transfer;
                  next_r.bus_count = adc_seq_pkg::transfer_bus_cycles;
               end else begin
                  next_r.count = r.count - 6'h1;
               end
            end
         end
         adc_seq_pkg::st_transfer: begin
            if (r.bus_count != 3'h1) begin
               next_r.bus_count = r.bus_count - 3'h1;
            end else begin
               res = ten ? core_result : {2'h0, core_result[7:0]};
               cmp = ten ? r.compare : {2'h0, r.compare[7:0]};
               diff = {1'b0, res} + {1'b1, ~cmp} + 11'h1;
               hit = r.sc2[adc_seq_pkg::sc2_compare_greater_bit]
                     ? !diff[10] : diff[10];
               do_store = !r.sc2[adc_seq_pkg::sc2_compare_enable_bit]
                          || hit;
               next_r.state = adc_seq_pkg::st_idle;
               if (do_store && !r.read_half) begin
                  next_r.result = r.sc2[adc_seq_pkg::sc2_compare_enable_bit]
                     ? diff[9:0] : res;
                  next_r.sc1[adc_seq_pkg::sc1_complete_bit] = 1'b1;
               end
               restart = r.sc1[adc_seq_pkg::sc1_continuous_bit]
                  || (r.read_half
                      && (do_store || r.sc1[adc_seq_pkg::sc1_continuous_bit]));
            end
         end
         default: next_r.state = adc_seq_pkg::st_idle;
      endcase
      if (r.stop_sync[1] && !async_sel && conv_run) begin
         next_r.state = adc_seq_pkg::st_idle;
         restart = 1'b0;
      end else if (abort) begin
         next_r.state = adc_seq_pkg::st_idle;
      end
      if ((start && !(r.stop_sync[1] && !async_sel)) || restart) begin
         next_r.first = start;
         if (async_sel && start) begin
            next_r.state = adc_seq_pkg::st_startup;
            next_r.count = adc_seq_pkg::async_startup_count;
         end else begin
            next_r.state = adc_seq_pkg::st_sample;
            next_r.count = r.cfg[adc_seq_pkg::cfg_long_sample_bit]
               ? adc_seq_pkg::sample_long_cycles
               : adc_seq_pkg::sample_short_cycles;
         end
      end
      next_r.irq = next_r.sc1[adc_seq_pkg::sc1_complete_bit]
                   & next_r.sc1[adc_seq_pkg::sc1_irq_enable_bit];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
         r.sc1 <= adc_seq_pkg::status_control_first_reset;
         r.state <= adc_seq_pkg::st_idle;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign conversion_irq = r.irq;
   assign async_clock_enable = r.state != adc_seq_pkg::st_idle
      && r.cfg[1:0] == adc_seq_pkg::clock_async;
   assign core_sample = r.state == adc_seq_pkg::st_sample;
   assign core_convert = r.state == adc_seq_pkg::st_approx;
   assign core_channel = r.sc1[4:0];
   assign core_low_power = r.cfg[adc_seq_pkg::cfg_low_power_bit];
   assign core_ten_bit = r.cfg[3] & ~r.cfg[2];
endmodule : adc_conversion_sequencer

// *** inc/adc_seq_pkg.sv ***
package adc_seq_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [4:0] status_control_first_addr = 5'h00;
   localparam logic [4:0] status_control_second_addr = 5'h04;
   localparam logic [4:0] result_high_addr = 5'h08;
   localparam logic [4:0] result_low_addr = 5'h0c;
   localparam logic [4:0] compare_value_high_addr = 5'h10;
   localparam logic [4:0] compare_value_low_addr = 5'h14;
   localparam logic [4:0] converter_configuration_addr = 5'h18;
   localparam logic [4:0] mode_control_addr = 5'h1c;
   // ==========================================================
   // field positions
   localparam int sc1_complete_bit = 7;
   localparam int sc1_irq_enable_bit = 6;
   localparam int sc1_continuous_bit = 5;
   localparam int sc2_active_bit = 7;
   localparam int sc2_hw_trigger_bit = 6;
   localparam int sc2_compare_enable_bit = 5;
   localparam int sc2_compare_greater_bit = 4;
   localparam int cfg_low_power_bit = 7;
   localparam int cfg_long_sample_bit = 4;
   localparam logic [4:0] channel_disabled = 5'h1f;
   localparam logic [1:0] mode_ten_bit = 2'h2;
   localparam logic [1:0] clock_async = 2'h3;
   localparam logic [7:0] status_control_first_reset = 8'h1f;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   // ==========================================================
   // timing, in conversion clock cycles, async startup and transfer in bus clock cycles
   localparam logic [5:0] sample_short_cycles = 6'h03;
   localparam logic [5:0] sample_long_cycles = 6'h17;
   localparam logic [5:0] approx_8bit_cycles = 6'h0c;
   localparam logic [5:0] approx_10bit_cycles = 6'h0f;
   localparam logic [5:0] first_extra_cycles = 6'h03;
   localparam int bus_clock_mhz = 10;
   localparam int async_startup_us = 5;
   localparam int async_startup_cycles = async_startup_us * bus_clock_mhz;
   localparam logic [5:0] async_startup_count = 6'(async_startup_cycles);
   localparam logic [2:0] transfer_bus_cycles = 3'h5;

   typedef enum logic [2:0] {
      st_idle, st_startup, st_sample, st_approx, st_transfer
   } seq_state_t;
endpackage : adc_seq_pkg

// *** rtl/conv_clock_divider.sv ***
module conv_clock_divider (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [1:0] source_select,
   input wire logic [1:0] divide_select,
   input wire logic alternate_clock,
   input wire logic async_conversion_clock,
   output logic tick
);
   // ==========================================================
   // source edge detection and divide by 1, 2, 4 or 8
   typedef struct packed {
      logic alt_meta;
      logic alt_sync;
      logic alt_last;
      logic ack_meta;
      logic ack_sync;
      logic ack_last;
      logic half;
      logic [2:0] count;
      logic tick;
   } div_state_t;

   div_state_t r;
   div_state_t next_r;
   logic src_edge;
   logic [2:0] limit;

   always_comb begin
      next_r = r;
      next_r.alt_meta = alternate_clock;
      next_r.alt_sync = r.alt_meta;
      next_r.alt_last = r.alt_sync;
      next_r.ack_meta = async_conversion_clock;
      next_r.ack_sync = r.ack_meta;
      next_r.ack_last = r.ack_sync;
      next_r.half = ~r.half;
      case (source_select)
         2'h0: src_edge = 1'b1;
         2'h1: src_edge = r.half;
         2'h2: src_edge = r.alt_sync & ~r.alt_last;
         default: src_edge = r.ack_sync & ~r.ack_last;
      endcase
      limit = 3'((4'h1 << divide_select) - 4'h1);
      next_r.tick = 1'b0;
      if (!run) begin
         next_r.count = 3'h0;
      end else if (src_edge) begin
         if (r.count >= limit) begin
            next_r.count = 3'h0;
            next_r.tick = 1'b1;
         end else begin
            next_r.count = r.count + 3'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick = r.tick;
endmodule : conv_clock_divider

// *** dv/sar_core_model.sv ***
module sar_core_model #(
   parameter logic [9:0] level = 10'h2a5
) (
   input wire logic core_sample,
   input wire logic core_convert,
   input wire logic core_ten_bit,
   input wire logic async_clock_enable,
   output logic [9:0] core_result,
   output logic async_conversion_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // analog core
   logic [9:0] held = 10'h000;
   initial async_conversion_clock = 1'b0;
   // the clock stands still until the sequencer enables it
   always #235 if (async_clock_enable)
      async_conversion_clock = ~async_conversion_clock;
   // the code settles when approximation ends
   always @(negedge core_convert)
      held = core_ten_bit ? level : {2'h0, level[9:2]};
   // mid conversion the output is not yet valid
   assign core_result = (core_sample || core_convert) ? ~held : held;
endmodule : sar_core_model

// *** dv/adc_conversion_sequencer_checker.sv ***
module seq_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic core_sample,
   input wire logic core_convert,
   input wire logic conversion_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // helpers
   logic [3:0] since_conv;
   logic [4:0] last_ar;
   always_ff @(posedge aclk) begin
      if (!aresetn || core_convert) since_conv <= 4'h0;
      else if (since_conv != 4'hf) since_conv <= since_conv + 4'h1;
      if (!aresetn) last_ar <= 5'h00;
      else if (s_axi_arvalid && s_axi_arready) last_ar <= s_axi_araddr;
   end
   // ==========================================================
   // properties
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !conversion_irq && !core_convert)
      else $error("outputs active after reset");
   a_phase_excl: assert property (!(core_sample && core_convert))
      else $error("sample and convert together");
   a_sample_first: assert property ($rose(core_convert) |->
      $past(core_sample)) else $error("convert without sampling");
   a_irq_transfer: assert property ($rose(conversion_irq) |->
      since_conv inside {[2:12]}) else $error("irq not after transfer");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   a_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_addr_error: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == adc_seq_pkg::resp_slverr
      && s_axi_rdata == 32'h0) else $error("unaligned read not refused");
   a_sc2_reserved: assert property (s_axi_rvalid &&
      last_ar == adc_seq_pkg::status_control_second_addr |->
      s_axi_rdata[3:2] == 2'h0) else $error("reserved bits not zero");
   a_byte_wide: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
   c_done: cover property ($rose(conversion_irq));
   c_convert: cover property ($rose(core_convert));
   c_refused: cover property (s_axi_rvalid &&
      s_axi_rresp == adc_seq_pkg::resp_slverr);
endmodule : seq_checker

bind adc_conversion_sequencer seq_checker u_chk (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .core_sample, .core_convert, .conversion_irq);

// *** dv/adc_conversion_sequencer_bench.sv ***
module adc_conversion_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] level = 10'h2a5;
   localparam logic [4:0] sc1 = adc_seq_pkg::status_control_first_addr;
   localparam logic [4:0] sc2 = adc_seq_pkg::status_control_second_addr;
   localparam logic [4:0] cfg = adc_seq_pkg::converter_configuration_addr;
   localparam logic [4:0] rh = adc_seq_pkg::result_high_addr;
   localparam logic [4:0] rl = adc_seq_pkg::result_low_addr;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic hardware_trigger_input = 1'b0, wait_mode = 1'b0;
   logic stop_mode = 1'b0, alternate_clock = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, conversion_irq, async_clock_enable, core_sample;
   logic core_convert, core_low_power, core_ten_bit, async_conversion_clock;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] core_channel;
   logic [9:0] core_result;
   int n_fail = 0;
   int checks_done = 0;
   always #50 aclk = ~aclk;
   always #310 alternate_clock = ~alternate_clock;

   adc_conversion_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .hardware_trigger_input, .wait_mode, .stop_mode, .alternate_clock,
      .async_conversion_clock, .core_result, .conversion_irq,
      .async_clock_enable, .core_sample, .core_convert, .core_channel,
      .core_low_power, .core_ten_bit);
   sar_core_model #(.level(level)) core (.core_sample, .core_convert,
      .core_ten_bit, .async_clock_enable, .core_result,
      .async_conversion_clock);

   // ==========================================================
   // tasks
   task automatic results();
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic check(input string s, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      check("bresp", adc_seq_pkg::resp_okay, s_axi_bresp);
      if (n >= 50) check("write_timeout", 0, 1);
      if (n >= 50) results();
   endtask : wr
   task automatic rdc(input string s, input logic [4:0] a,
         input logic [31:0] e);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      check(s, e, (a[1:0] != 2'h0) ? {30'h0, s_axi_rresp} : s_axi_rdata);
      if (n >= 50) check("read_timeout", 0, 1);
      if (n >= 50) results();
   endtask : rdc
   task automatic wirq(input int lim, output int c);
      c = 0;
      while (conversion_irq !== 1'b1 && c < lim) begin
         @(posedge aclk);
         c++;
      end
   endtask : wirq

   // ==========================================================
   // sequence
   initial begin
      static logic [7:0] cfgs [6] = '{8'h08, 8'h18, 8'h00, 8'h10, 8'h0b,
         8'h29};
      static int lims [6] = '{32, 52, 29, 49, 174, 101};
      static logic [9:0] cvs [4] = '{10'h31c, 10'h10e, 10'h31c, 10'h10e};
      logic [9:0] res;
      logic hit;
      int c;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("sc1_reset", sc1, {24'h0, adc_seq_pkg::status_control_first_reset});
      rdc("rh_reset", rh, 32'h0);
      rdc("bad_addr", 5'h02, {30'h0, adc_seq_pkg::resp_slverr});
      for (int i = 0; i < 6; i++) begin
         wr(cfg, cfgs[i]);
         wr(sc2, 8'h00);
         wr(sc1, 8'h41);
         wirq(400, c);
         check("conv_time", 1, c <= lims[i]);
         check("channel", 32'h1, core_channel);
         if (cfgs[i][3:2] == adc_seq_pkg::mode_ten_bit)
            rdc("res_high", rh, {30'h0, level[9:8]});
         rdc("res_low", rl, cfgs[i][3] ? level[7:0] : level[9:2]);
         @(posedge aclk);
         check("irq_clear", 0, conversion_irq);
      end
      res = level;
      wr(cfg, 8'h08);
      for (int j = 0; j < 4; j++) begin
         hit = (j < 2) ? (level >= cvs[j]) : (level < cvs[j]);
         if (hit) res = level - cvs[j];
         wr(sc2, (j < 2) ? 8'h30 : 8'h20);
         wr(adc_seq_pkg::compare_value_high_addr, {6'h0, cvs[j][9:8]});
         wr(adc_seq_pkg::compare_value_low_addr, cvs[j][7:0]);
         wr(sc1, 8'h41);
         wirq(80, c);
         check("cmp_flag", hit, c < 80);
         rdc("cmp_high", rh, {30'h0, res[9:8]});
         rdc("cmp_low", rl, res[7:0]);
      end
      wr(sc2, 8'h00);
      wr(sc1, 8'h41);
      repeat (10) @(posedge aclk);
      wr(sc1, 8'h41);
      wirq(80, c);
      check("restart", 1, c > 20 && c <= 32);
      rdc("restart_low", rl, level[7:0]);
      wr(sc1, 8'h41);
      rdc("active", sc2, 32'h80);
      wr(cfg, 8'h08);
      rdc("aborted", sc2, 32'h00);
      wirq(80, c);
      check("abort_done", 0, c < 80);
      wr(sc1, 8'h5f);
      wirq(80, c);
      check("chan_off", 0, c < 80);
      wr(sc1, 8'h61);
      wirq(80, c);
      rdc("cont_first", rl, level[7:0]);
      wirq(80, c);
      check("cont_next", 1, c < 80);
      wr(sc1, 8'h5f);
      rdc("cont_low", rl, level[7:0]);
      wr(sc2, 8'h40);
      wr(sc1, 8'h41);
      wirq(80, c);
      check("hw_idle", 0, c < 80);
      hardware_trigger_input <= 1'b1;
      wirq(80, c);
      check("hw_start", 1, c < 80);
      hardware_trigger_input <= 1'b0;
      rdc("hw_low", rl, level[7:0]);
      wr(sc2, 8'h00);
      wr(sc1, 8'h41);
      wait_mode <= 1'b1;
      wirq(80, c);
      check("wait_done", 1, c < 80);
      wait_mode <= 1'b0;
      rdc("wait_low", rl, level[7:0]);
      wr(sc1, 8'h41);
      stop_mode <= 1'b1;
      wirq(80, c);
      check("stop_abort", 0, c < 80);
      stop_mode <= 1'b0;
      wirq(80, c);
      check("stop_exit", 0, c < 80);
      wr(cfg, 8'h0b);
      wr(sc1, 8'h41);
      stop_mode <= 1'b1;
      wirq(400, c);
      check("stop_async", 1, c < 400);
      stop_mode <= 1'b0;
      rdc("stop_low", rl, level[7:0]);
      wr(sc1, 8'h41);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("rst_low", rl, 32'h0);
      results();
   end
endmodule : adc_conversion_sequencer_bench
